// *** design/cbs_eval.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1: flag-high branch jumps to pc+k+1 when flag_word bit s is one.
// RL2: flag-low branch jumps to pc+k+1 when flag_word bit s is zero.
// RL3: equal branch jumps when zero flag is one, else falls through.
// RL4: unequal branch jumps when zero flag is zero, else falls through.
// RL5: carry-high and unsigned-below branches jump when carry is one.
// RL6: carry-low and unsigned-at-least branches jump when carry is zero.
// RL7: negative branch jumps on N one; positive branch on N zero.
// RL8: signed-at-least branch jumps when N xor V is zero.
// RL9: signed-below branch jumps when N xor V is one.
// RL10: half-carry-high branch jumps when H is one.
// RL11: half-carry-low branch jumps when H is zero.
// RL12: copy-bit-high branch jumps when T is one.
// RL13: copy-bit-low branch jumps when T is zero.
// RL14: overflow-high branch jumps when V is one.
// RL15: overflow-low branch jumps when V is zero.
// RL16: io-bit-low skip advances pc by two or three when bit b is zero.
// RL17: io-bit-high skip advances pc by two or three when bit b is one.
// RL18: k is signed; untaken branch one cycle, taken branch two cycles.
module cbs_eval
    import cbs_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // Request from the decoder
    input  wire logic       req_valid_i,
    input  wire cbs_req_t   req_i,
    input  wire logic [7:0] flag_word_i,
    // Result to the fetch logic
    output logic            req_ready_o,
    output logic            rsp_valid_o,
    output cbs_rsp_t        rsp_o
);

    // ---------------------------------------------------------------
    // Condition evaluation
    // ---------------------------------------------------------------
    logic            cond;
    logic            is_skip;
    logic [2:0]      bit_sel;

    // Picks the tested flag or I/O bit; the flag word is only read, never changed.
    always_comb begin
        cond    = 1'b0;
        is_skip = 1'b0;
        bit_sel = req_i.sel;
        unique case (req_i.op)
            CBS_OP_BRANCH_ON_FLAG_HIGH:      cond = flag_word_i[bit_sel];          // RL1
            CBS_OP_BRANCH_ON_FLAG_LOW:       cond = ~flag_word_i[bit_sel];         // RL2
            CBS_OP_BRANCH_WHEN_EQUAL:        cond = flag_word_i[FLAG_Z];           // RL3
            CBS_OP_BRANCH_WHEN_UNEQUAL:      cond = ~flag_word_i[FLAG_Z];          // RL4
            CBS_OP_BRANCH_WHEN_CARRY_HIGH,
            CBS_OP_BRANCH_UNSIGNED_BELOW:    cond = flag_word_i[FLAG_C];           // RL5
            CBS_OP_BRANCH_WHEN_CARRY_LOW,
            CBS_OP_BRANCH_UNSIGNED_AT_LEAST: cond = ~flag_word_i[FLAG_C];          // RL6
            CBS_OP_BRANCH_WHEN_NEGATIVE:     cond = flag_word_i[FLAG_N];           // RL7
            CBS_OP_BRANCH_WHEN_POSITIVE:     cond = ~flag_word_i[FLAG_N];          // RL7
            CBS_OP_BRANCH_SIGNED_AT_LEAST:
                cond = ~(flag_word_i[FLAG_N] ^ flag_word_i[FLAG_V]);               // RL8
            CBS_OP_BRANCH_SIGNED_BELOW:
                cond = flag_word_i[FLAG_N] ^ flag_word_i[FLAG_V];                  // RL9
            CBS_OP_BRANCH_HALF_CARRY_HIGH:   cond = flag_word_i[FLAG_H];           // RL10
            CBS_OP_BRANCH_HALF_CARRY_LOW:    cond = ~flag_word_i[FLAG_H];          // RL11
            CBS_OP_BRANCH_COPY_BIT_HIGH:     cond = flag_word_i[FLAG_T];           // RL12
            CBS_OP_BRANCH_COPY_BIT_LOW:      cond = ~flag_word_i[FLAG_T];          // RL13
            CBS_OP_BRANCH_OVERFLOW_HIGH:     cond = flag_word_i[FLAG_V];           // RL14
            CBS_OP_BRANCH_OVERFLOW_LOW:      cond = ~flag_word_i[FLAG_V];          // RL15
            CBS_OP_SKIP_ON_IO_BIT_LOW: begin
                cond    = ~req_i.io_data[bit_sel];                                 // RL16
                is_skip = 1'b1;
            end
            CBS_OP_SKIP_ON_IO_BIT_HIGH: begin
                cond    = req_i.io_data[bit_sel];                                  // RL17
                is_skip = 1'b1;
            end
            default: begin
                cond    = 1'b0;
                is_skip = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Target computation
    // ---------------------------------------------------------------
    logic [PC_W-1:0] disp_ext;
    logic [PC_W-1:0] target;
    logic [1:0]      cyc_need;

    // Sign-extends k and forms the next program counter and cycle count.
    always_comb begin
        disp_ext = {{(PC_W-DISP_W){req_i.disp[DISP_W-1]}}, req_i.disp};           // RL18
        target   = req_i.pc + PC_STEP_ONE;
        cyc_need = CYC_FALL;
        if (cond && !is_skip) begin
            target   = req_i.pc + disp_ext + PC_STEP_ONE;                          // RL1
            cyc_need = CYC_TAKEN;                                                  // RL18
        end else if (cond && is_skip) begin
            target   = req_i.pc + (req_i.next_is_long ? PC_STEP_THREE : PC_STEP_TWO); // RL16
            cyc_need = req_i.next_is_long ? CYC_SKIP_LONG : CYC_TAKEN;             // RL17
        end
    end

    // ---------------------------------------------------------------
    // Cycle sequencing
    // ---------------------------------------------------------------
    cbs_state_t state_q, state_d;
    cbs_rsp_t   rsp_q, rsp_d;
    logic       valid_q, valid_d;

    // Holds the result for the extra cycles a taken branch or skip needs.
    always_comb begin
        state_d = state_q;
        rsp_d   = rsp_q;
        valid_d = 1'b0;
        unique case (state_q)
            CBS_ST_IDLE: begin
                if (req_valid_i) begin
                    rsp_d.taken   = cond & ~is_skip;
                    rsp_d.skip    = cond & is_skip;
                    rsp_d.next_pc = target;
                    rsp_d.cycles  = cyc_need;
                    if (cyc_need == CYC_FALL) begin
                        valid_d = 1'b1;                                            // RL18
                    end else begin
                        state_d = (cyc_need == CYC_SKIP_LONG) ? CBS_ST_WAIT2 : CBS_ST_WAIT1;
                    end
                end
            end
            CBS_ST_WAIT2: state_d = CBS_ST_WAIT1;
            CBS_ST_WAIT1: begin
                state_d = CBS_ST_IDLE;
                valid_d = 1'b1;
            end
            default: state_d = CBS_ST_IDLE;
        endcase
    end

    // Registers the sequencer state and result.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= CBS_ST_IDLE;
            rsp_q   <= '0;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rsp_q   <= rsp_d;
            valid_q <= valid_d;
        end
    end

    // Ready only while idle; result comes from flip-flops.
    assign req_ready_o = (state_q == CBS_ST_IDLE);
    assign rsp_valid_o = valid_q;
    assign rsp_o       = rsp_q;

endmodule // cbs_eval

`default_nettype wire

// *** design/cbs_pkg.sv ***
package cbs_pkg;

    // ---------------------------------------------------------------
    // Widths and flag positions in the flag word
    // ---------------------------------------------------------------
    localparam int unsigned PC_W     = 16;
    localparam int unsigned DISP_W   = 7;
    localparam int unsigned FLAG_C   = 0;
    localparam int unsigned FLAG_Z   = 1;
    localparam int unsigned FLAG_N   = 2;
    localparam int unsigned FLAG_V   = 3;
    localparam int unsigned FLAG_S   = 4;
    localparam int unsigned FLAG_H   = 5;
    localparam int unsigned FLAG_T   = 6;
    localparam int unsigned FLAG_I   = 7;

    // ---------------------------------------------------------------
    // Program counter steps and reset values
    // ---------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_STEP_ONE   = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_TWO   = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;
    localparam logic [PC_W-1:0] PC_RESET      = 16'h0000;

    // ---------------------------------------------------------------
    // Cycle counts of a resolved instruction
    // ---------------------------------------------------------------
    localparam logic [1:0] CYC_FALL      = 2'h1;
    localparam logic [1:0] CYC_TAKEN     = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG = 2'h3;

    // Operation codes presented by the decoder.
    typedef enum logic [4:0] {
        CBS_OP_BRANCH_ON_FLAG_HIGH       = 5'b00000,
        CBS_OP_BRANCH_ON_FLAG_LOW        = 5'b00001,
        CBS_OP_BRANCH_WHEN_EQUAL         = 5'b00010,
        CBS_OP_BRANCH_WHEN_UNEQUAL       = 5'b00011,
        CBS_OP_BRANCH_WHEN_CARRY_HIGH    = 5'b00100,
        CBS_OP_BRANCH_WHEN_CARRY_LOW     = 5'b00101,
        CBS_OP_BRANCH_UNSIGNED_AT_LEAST  = 5'b00110,
        CBS_OP_BRANCH_UNSIGNED_BELOW     = 5'b00111,
        CBS_OP_BRANCH_WHEN_NEGATIVE      = 5'b01000,
        CBS_OP_BRANCH_WHEN_POSITIVE      = 5'b01001,
        CBS_OP_BRANCH_SIGNED_AT_LEAST    = 5'b01010,
        CBS_OP_BRANCH_SIGNED_BELOW       = 5'b01011,
        CBS_OP_BRANCH_HALF_CARRY_HIGH    = 5'b01100,
        CBS_OP_BRANCH_HALF_CARRY_LOW     = 5'b01101,
        CBS_OP_BRANCH_COPY_BIT_HIGH      = 5'b01110,
        CBS_OP_BRANCH_COPY_BIT_LOW       = 5'b01111,
        CBS_OP_BRANCH_OVERFLOW_HIGH      = 5'b10000,
        CBS_OP_BRANCH_OVERFLOW_LOW       = 5'b10001,
        CBS_OP_SKIP_ON_IO_BIT_LOW        = 5'b10010,
        CBS_OP_SKIP_ON_IO_BIT_HIGH       = 5'b10011
    } cbs_op_t;

    // Evaluator states.
    typedef enum logic [1:0] {
        CBS_ST_IDLE  = 2'b00,
        CBS_ST_WAIT1 = 2'b01,
        CBS_ST_WAIT2 = 2'b10
    } cbs_state_t;

    // One instruction handed to the evaluator.
    typedef struct packed {
        cbs_op_t           op;
        logic [2:0]        sel;
        logic [DISP_W-1:0] disp;
        logic [PC_W-1:0]   pc;
        logic [7:0]        io_data;
        logic              next_is_long;
    } cbs_req_t;

    // Result handed back to the fetch logic.
    typedef struct packed {
        logic            taken;
        logic            skip;
        logic [PC_W-1:0] next_pc;
        logic [1:0]      cycles;
    } cbs_rsp_t;

endpackage

// *** verification/cbs_eval_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbs_eval_monitor
    import cbs_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    // Request side
    input wire logic       req_valid_i,
    input wire cbs_req_t   req_i,
    input wire logic [7:0] flag_word_i,
    // Result side
    input wire logic       req_ready_o,
    input wire logic       rsp_valid_o,
    input wire cbs_rsp_t   rsp_o
);
    logic            take;
    logic            io_bit;
    logic            nv_x;
    logic [PC_W-1:0] tgt;
    logic [PC_W-1:0] pc1;
    logic [PC_W-1:0] pcs;
    // Reference values captured at the accepting edge.
    assign take   = req_valid_i & req_ready_o;
    assign io_bit = req_i.io_data[req_i.sel];
    assign nv_x   = flag_word_i[FLAG_N] ^ flag_word_i[FLAG_V];
    assign tgt    = req_i.pc + {{9{req_i.disp[6]}}, req_i.disp} + PC_STEP_ONE;
    assign pc1    = req_i.pc + PC_STEP_ONE;
    assign pcs    = req_i.pc + (req_i.next_is_long ? PC_STEP_THREE : PC_STEP_TWO);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_untaken_one_cycle: assert property (take ##1 (rsp_o.cycles == 2'd1)
        |-> rsp_valid_o && req_ready_o) else $error("untaken result late");
    a_taken_two_cycles: assert property (take ##1 rsp_o.taken
        |-> !req_ready_o && !rsp_valid_o ##1 rsp_valid_o) else $error("taken timing");
    a_skip_long_wait: assert property (take ##1 (rsp_o.skip && rsp_o.cycles == 2'd3)
        |-> !rsp_valid_o[*2] ##1 rsp_valid_o) else $error("long skip timing");
    a_taken_target: assert property (take ##1 rsp_o.taken
        |-> rsp_o.next_pc == $past(tgt)) else $error("branch target wrong");
    a_fall_through: assert property (take ##1 (!rsp_o.taken && !rsp_o.skip)
        |-> rsp_o.next_pc == $past(pc1)) else $error("fall through pc wrong");
    a_skip_distance: assert property (take ##1 rsp_o.skip
        |-> rsp_o.next_pc == $past(pcs)) else $error("skip distance wrong");
    a_equal_zero: assert property (take && req_i.op == CBS_OP_BRANCH_WHEN_EQUAL
        |=> rsp_o.taken == $past(flag_word_i[FLAG_Z])) else $error("equal branch wrong");
    a_unequal_zero: assert property (take && req_i.op == CBS_OP_BRANCH_WHEN_UNEQUAL
        |=> rsp_o.taken != $past(flag_word_i[FLAG_Z])) else $error("unequal branch wrong");
    a_carry_low: assert property (take && req_i.op == CBS_OP_BRANCH_WHEN_CARRY_LOW
        |=> rsp_o.taken != $past(flag_word_i[FLAG_C])) else $error("carry low wrong");
    a_signed_below: assert property (take && req_i.op == CBS_OP_BRANCH_SIGNED_BELOW
        |=> rsp_o.taken == $past(nv_x)) else $error("signed below wrong");
    a_io_high_skip: assert property (take && req_i.op == CBS_OP_SKIP_ON_IO_BIT_HIGH
        |=> rsp_o.skip == $past(io_bit)) else $error("io high skip wrong");
    a_busy_no_result: assert property (!req_ready_o |-> !rsp_valid_o)
        else $error("result while busy");
endmodule // cbs_eval_monitor
bind cbs_eval cbs_eval_monitor u_cbs_eval_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .flag_word_i(flag_word_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
`default_nettype wire

// *** verification/conditional_branch_skip_eval_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_skip_eval_tb
    import cbs_pkg::*;
;
    logic        core_clk_i, rst_i, req_valid_i, req_ready_o, rsp_valid_o;
    logic [7:0]  flag_word_i;
    cbs_req_t    req_i;
    cbs_rsp_t    rsp_o;
    logic [31:0] seed = 32'h0000_c4aa;
    int          n_mismatch = 0;
    int          n_tests = 0;
    cbs_eval u_cbs_eval (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .flag_word_i(flag_word_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
    // Free running 100 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // Repeatable pseudo random source.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Condition of the current request; odd codes test the opposite level, but in pairs 6-7, 10-11 and 18-19 the even codes do.
    function automatic logic cond();
        logic v;
        case (req_i.op[4:1])
            4'd0: v = flag_word_i[req_i.sel];
            4'd1: v = flag_word_i[FLAG_Z];
            4'd2, 4'd3: v = flag_word_i[FLAG_C];
            4'd4: v = flag_word_i[FLAG_N];
            4'd5: v = flag_word_i[FLAG_N] ^ flag_word_i[FLAG_V];
            4'd6: v = flag_word_i[FLAG_H];
            4'd7: v = flag_word_i[FLAG_T];
            4'd8: v = flag_word_i[FLAG_V];
            default: v = req_i.io_data[req_i.sel];
        endcase
        return v ^ req_i.op[0] ^ (req_i.op[4:1] inside {4'd3, 4'd5, 4'd9});
    endfunction
    // Compares one observed value with its expectation.
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Issues the held request and checks the result and its latency.
    task automatic run();
        logic c, sk;
        int n, en;
        logic [PC_W-1:0] ep;
        c  = cond();
        sk = (req_i.op[4:1] == 4'd9);
        en = !c ? 1 : (!sk ? 2 : (req_i.next_is_long ? 3 : 2));
        ep = !c ? req_i.pc + 16'h0001 : sk ? req_i.pc + (req_i.next_is_long ? 16'h0003 : 16'h0002)
            : req_i.pc + {{9{req_i.disp[6]}}, req_i.disp} + 16'h0001;
        req_valid_i = 1'b1;
        @(posedge core_clk_i);
        #1 req_valid_i = (en > 1);
        if (en > 1) req_i.pc = ~req_i.pc;
        n = 1;
        while (rsp_valid_o !== 1'b1 && n < 8) begin
            @(posedge core_clk_i);
            #1 n++;
            req_valid_i = 1'b0;
        end
        chk("latency", n, en);
        chk("ready", req_ready_o, 1'b1);
        chk("cycles", rsp_o.cycles, en[1:0]);
        chk("taken", rsp_o.taken, c & !sk);
        chk("skip", rsp_o.skip, c & sk);
        chk("next_pc", rsp_o.next_pc, ep);
    endtask
    // Watchdog for a hung handshake.
    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_mismatch++;
        conclude();
    end
    // Reset check, then every code many times with random operands.
    initial begin
        logic [31:0] t;
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        flag_word_i = 8'h00;
        repeat (5) @(posedge core_clk_i);
        #1 chk("reset state", {req_ready_o, rsp_valid_o, rsp_o}, {2'b10, 20'h0_0000});
        rst_i = 1'b0;
        for (int i = 0; i < 300; i++) begin
            t = xs();
            req_i.op = cbs_op_t'(5'(i % 20));
            req_i.pc = t[15:0];
            {req_i.sel, req_i.disp, req_i.io_data, req_i.next_is_long} = {t[31:16], t[2:0]};
            t = xs();
            flag_word_i = t[7:0];
            if (i < 40) req_i.disp = (i < 20) ? 7'h40 : 7'h3f;
            if (i < 20) req_i.pc = 16'hfffe;
            run();
        end
        conclude();
    end
endmodule // conditional_branch_skip_eval_tb
`default_nettype wire
